// file: bench/aorf_sink_model.sv
// receiving logic model: random stalls, captures word and flag together
// assumes words arrive under valid/ready on clock_i
`timescale 1ns/1ps
module aorf_sink_model (
  // clock, reset and stall request
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        hold_i,
  // word side
  input  wire logic        valid_i,
  input  wire logic [11:0] code_i,
  input  wire logic        flag_i,
  output logic             ready_o,
  output logic [11:0]      twos_o,
  output logic [1:0]       range_o,
  // conversion clock made from clock_i
  output logic             conv_clk_o
);
  int seed = 87221;
  logic div;
  // divide-by-two flop, then retimed by its source clock as the last step
  always @(posedge clock_i) begin
    div <= resetn_i ? ~div : 1'b0;
    conv_clk_o <= resetn_i ? div : 1'b0;
  end
  always @(posedge clock_i) begin
    ready_o <= resetn_i && !hold_i && $random(seed) % 4 != 0;
    if (valid_i && ready_o) twos_o <= {~code_i[11], code_i[10:0]};
    if (valid_i && ready_o) range_o <= {flag_i & code_i[11], flag_i & ~code_i[11]};
  end
endmodule // aorf_sink_model

// file: bench/aorf_top_properties.sv
// port checker for the converter output stage
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module aorf_top_properties #(
  parameter int PIPE = 3
) (
  // clock and reset
  input wire logic        clock_i,
  input wire logic        resetn_i,
  // sample and word sides
  input wire logic        sample_valid_i,
  input wire logic        sample_ready_o,
  input wire logic        data_valid_o,
  input wire logic        data_ready_i,
  input wire logic [11:0] data_code_o,
  input wire logic        out_of_range_flag_o
);
  localparam int LO = PIPE + 1;
  // stalls hold the old word up, so a late bound is safe
  localparam int HI = PIPE + 5;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  sequence s_take; sample_valid_i && sample_ready_o; endsequence
  sequence s_out; data_valid_o && data_ready_i; endsequence
  property p_lat; s_take |-> ##[LO:HI] data_valid_o; endproperty
  property p_hold; data_valid_o && !data_ready_i |=>
    data_valid_o && $stable({out_of_range_flag_o, data_code_o}); endproperty
  property p_end; data_valid_o && out_of_range_flag_o |->
    data_code_o inside {12'h000, 12'hfff}; endproperty
  property p_in; data_valid_o && !(data_code_o inside {12'h000, 12'hfff}) |->
    !out_of_range_flag_o; endproperty
  property p_fall; $fell(out_of_range_flag_o) |-> $past(!data_valid_o || data_ready_i);
  endproperty
  property p_full; !sample_ready_o |-> data_valid_o; endproperty
  property p_drain; s_out |=> sample_ready_o; endproperty
  property p_rise; $rose(sample_ready_o) |-> $past(data_valid_o && data_ready_i);
  endproperty
  a_lat: assert property (p_lat) else $error("word late");
  a_hold: assert property (p_hold) else $error("word moved");
  a_end: assert property (p_end) else $error("flag without end code");
  a_in: assert property (p_in) else $error("flag on inner code");
  a_fall: assert property (p_fall) else $error("flag fell early");
  a_full: assert property (p_full) else $error("refused while empty");
  a_drain: assert property (p_drain) else $error("still refused");
  a_rise: assert property (p_rise) else $error("ready without drain");
endmodule // aorf_top_properties
bind aorf_top aorf_top_properties #(.PIPE(PIPE)) u_props (.clock_i, .resetn_i,
  .sample_valid_i, .sample_ready_o, .data_valid_o, .data_ready_i, .data_code_o,
  .out_of_range_flag_o);

// file: bench/testbench.sv
// self-checking bench for the converter output stage
// assumes the sink model on the far side and the bound checker
`timescale 1ns/1ps
module testbench;
  import aorf_pkg::*;
  logic clock_i, resetn_i, mode_single_i, sample_valid_i, hold;
  logic signed [IN_W-1:0] sample_i;
  logic sample_ready_o, data_valid_o, data_ready_i, out_of_range_flag_o;
  logic [CODE_W-1:0] data_code_o;
  logic [WORD_W-1:0] exp_q[$];
  logic [WORD_W-1:0] got_w;
  logic got_v = 1'b0;
  logic conv_clk;
  logic [CODE_W-1:0] twos;
  logic [1:0] range_v;
  int conv_n = 0;
  int failures = 0, check_count = 0, seed = 87221, i, m;
  int edge_v[8] = '{-2049, -2048, -1, 0, 2047, 2048, -4000, 4000};
  aorf_top dut (.clock_i, .resetn_i, .mode_single_i, .sample_valid_i, .sample_i,
    .sample_ready_o, .data_valid_o, .data_ready_i, .data_code_o, .out_of_range_flag_o);
  aorf_sink_model sink (.clock_i, .resetn_i, .hold_i(hold), .valid_i(data_valid_o),
    .code_i(data_code_o), .flag_i(out_of_range_flag_o), .ready_o(data_ready_i),
    .twos_o(twos), .range_o(range_v), .conv_clk_o(conv_clk));
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  task automatic chk(input string n, input logic [WORD_W-1:0] e, g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // sample must be set up a half cycle ahead, so it changes after the rising edge
  task automatic send(input int md, input int v);
    int d;
    d = md ? v - 2048 : v;
    sample_valid_i <= 1'b1;
    mode_single_i <= md[0];
    sample_i <= v[IN_W-1:0];
    do @(negedge clock_i); while (!sample_ready_o);
    @(posedge clock_i);
    if (d < -2048) exp_q.push_back({1'b1, 12'h000});
    else if (d > 2047) exp_q.push_back({1'b1, 12'hfff});
    else exp_q.push_back({1'b0, 12'(d + 2048)});
  endtask
  task automatic drain(input string n);
    sample_valid_i <= 1'b0;
    for (int j = 0; j < 300 && exp_q.size() > 0; j++) @(posedge clock_i);
    chk("pending", '0, 13'(exp_q.size()));
    $display("%s done", n);
  endtask
  task automatic results;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(negedge clock_i) begin
    if (got_v) begin
      chk("twos", 13'(12'(got_w[11:0] - CODE_MID)), 13'(twos));
      chk("range", got_w == {1'b1, CODE_MAX} ? 13'h2 :
        got_w == {1'b1, CODE_MIN} ? 13'h1 : 13'h0, 13'(range_v));
    end
    got_v = 1'b0;
    if (resetn_i && data_valid_o && data_ready_i) begin
      if (exp_q.size() == 0) chk("extra word", '0, '1);
      else begin
        got_w = exp_q.pop_front();
        got_v = 1'b1;
        chk("word", got_w, {out_of_range_flag_o, data_code_o});
      end
    end
  end
  always @(negedge clock_i)
    if (resetn_i) begin
      chk("conversion clock", 13'(conv_n > 0 && conv_n % 2 == 0), 13'(conv_clk));
      conv_n++;
    end
  initial begin
    repeat (5000) @(posedge clock_i);
    failures++;
    results();
  end
  initial begin
    resetn_i = 0; mode_single_i = 0; sample_valid_i = 0; sample_i = '0; hold = 0;
    repeat (20) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(negedge clock_i);
    chk("reset", 13'h1, {data_valid_o, sample_ready_o});
    @(posedge clock_i);
    for (m = 0; m < 2; m++)
      foreach (edge_v[k]) send(m, edge_v[k] + m * 2048);
    drain("end codes");
    hold <= 1'b1;
    fork begin
      repeat (12) @(posedge clock_i);
      chk("refused", '0, 13'(sample_ready_o));
      hold <= 1'b0;
    end join_none
    for (i = 0; i < 8; i++) send(0, i * 600 - 2400);
    drain("stall");
    for (i = 0; i < 200; i++) begin
      m = $random(seed) & 1;
      send(m, $random(seed) % 2400 + m * 2048);
    end
    drain("random");
    results();
  end
endmodule // testbench

// file: design/aorf_pkg.sv
// shared constants and types of the converter output-code and range-flag block
// assumes the sample arrives as a signed count of code steps, already on clock_i
package aorf_pkg;

  localparam int CODE_W     = 12;
  localparam int IN_W       = 14;
  localparam int PIPE_DEPTH = 3;
  localparam int BUF_DEPTH  = 2;

  localparam logic [CODE_W-1:0] CODE_MIN = 12'h000;
  localparam logic [CODE_W-1:0] CODE_MID = 12'h800;
  localparam logic [CODE_W-1:0] CODE_MAX = 12'hfff;

  // span limits of the difference input, in code steps
  localparam logic signed [IN_W:0] DIFF_NEG_LIMIT = -15'sh0800;
  localparam logic signed [IN_W:0] DIFF_POS_LIMIT = 15'sh0800;
  // single-ended input is referred to ground, so midscale is removed first
  localparam logic signed [IN_W:0] SINGLE_OFFSET  = 15'sh0800;

  typedef struct packed {
    logic              flag;
    logic [CODE_W-1:0] code;
  } aorf_word_s;

  localparam int WORD_W = CODE_W + 1;

  localparam aorf_word_s WORD_RESET = '{flag: 1'b0, code: CODE_MID};

  // saturating straight-binary coding of a signed difference
  function automatic aorf_word_s aorf_convert(input logic signed [IN_W:0] diff);
    aorf_word_s w;
    w = WORD_RESET;
    if (diff < DIFF_NEG_LIMIT) begin
      w.flag = 1'b1;
      w.code = CODE_MIN;
    end else if (diff >= DIFF_POS_LIMIT) begin
      w.flag = 1'b1;
      w.code = CODE_MAX;
    end else begin
      w.flag = 1'b0;
      // in range the offset to midscale is a plain flip of the top bit
      w.code = {~diff[CODE_W-1], diff[CODE_W-2:0]};
    end
    return w;
  endfunction

endpackage

// file: design/aorf_skid.sv
// two-entry buffer: output register plus one skid register
// assumes the filler honours ready and the drainer may stall at will
`timescale 1ns/1ps
module aorf_skid (
  // clock and reset
  input  wire logic    clock_i,
  input  wire logic    resetn_i,
  // filling and draining sides
  aorf_stream_if.snk   up,
  aorf_stream_if.src   down
);
  import aorf_pkg::*;

  localparam int W = $bits(up.data);

  logic [W-1:0] main_d;
  logic         main_v;
  logic [W-1:0] skid_d;
  logic         skid_v;
  logic         skid_free;
  logic         take;
  logic         pop;

  // ready is a flop term, so the filler never sees a combinational path back
  // ready is kept as its own flop so that the top's ready port is a plain flop
  assign up.ready   = skid_free;
  assign skid_v     = ~skid_free;
  assign down.valid = main_v;
  assign down.data  = main_d;
  assign take       = up.valid & ~skid_v;
  assign pop        = main_v & down.ready;

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      main_v <= 1'b0;
      main_d <= '0;
      skid_free <= 1'b1;
      skid_d <= '0;
    end else if (!main_v || pop) begin
      if (skid_v) begin
        main_d <= skid_d;
        main_v <= 1'b1;
        skid_free <= 1'b1;
      end else begin
        main_v <= take;
        if (take) begin
          main_d <= up.data;
        end
      end
    end else if (take) begin
      skid_free <= 1'b0;
      skid_d <= up.data;
    end
  end

endmodule // aorf_skid

// file: design/aorf_stream_if.sv
// valid/ready word carrier between the block's own modules
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface aorf_stream_if #(parameter int W = 13);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: design/aorf_top.sv
// Function
// - output is always unsigned straight binary
// - end codes 000, 800 mid, fff, saturated
// - flag travels with its own word
// - flag low for in-range samples
// - flag high beyond limits, with end code
// - flag stays high until in-range word output
// - timing uses both clock edges
// - single-ended input saturates at 000 and fff
//
// converter output stage: coding, range flag, pipeline and output buffer
// assumes sample_i is produced on clock_i and held while sample_ready_o is low
`timescale 1ns/1ps
module aorf_top #(
  parameter int PIPE = aorf_pkg::PIPE_DEPTH
) (
  // clock and reset
  input  wire logic                            clock_i,
  input  wire logic                            resetn_i,
  // input range selection
  input  wire logic                            mode_single_i,
  // sampled input
  input  wire logic                            sample_valid_i,
  input  wire logic signed [aorf_pkg::IN_W-1:0] sample_i,
  output logic                                 sample_ready_o,
  // converted output
  output logic                                 data_valid_o,
  input  wire logic                            data_ready_i,
  output logic [aorf_pkg::CODE_W-1:0]          data_code_o,
  output logic                                 out_of_range_flag_o
);
  import aorf_pkg::*;

  // timing of one sample, counted in clock_i periods:
  //   falling edge   the hold stage captures the coded word and its flag
  //   rising edge    stage 0 takes it if the buffer has room
  //   next edges     stages 1 .. PIPE-1, then the buffer's output flops
  // so a sample that is not stalled reaches the ports PIPE rising edges
  // after the edge that takes it; a stall adds cycles but never alters
  // the word itself or separates its flag from its code
  //
  // reset is synchronous on both edges that use it: the hold stage clears
  // on a falling edge and the pipeline on a rising edge, so reset has to
  // stand across at least one edge of each kind

  // the pipeline end feeds the buffer, the buffer's own flops drive the ports
  aorf_stream_if #(.W(WORD_W)) pipe_s ();
  aorf_stream_if #(.W(WORD_W)) out_s ();

  // sample as a sign-extended difference around midscale
  logic signed [IN_W:0] diff;

  // converted word of the sample now on the inputs
  aorf_word_s           conv_w;

  // falling-edge hold stage, one flop group per field
  logic                 hold_flag;
  logic [CODE_W-1:0]    hold_code;
  logic                 hold_v;

  // rising-edge pipeline stages, oldest at the highest index
  logic                 pipe_flag [PIPE];
  logic [CODE_W-1:0]    pipe_code [PIPE];
  logic                 pipe_v    [PIPE];

  // every stage moves on the same condition, so the fields stay in step
  logic                 advance;

  // word leaving the buffer, split back into its fields
  aorf_word_s           out_w;

  // widens the sample with its sign and, for a ground-referred input,
  // removes midscale so that both modes share one coding path
  function automatic logic signed [IN_W:0] aorf_to_diff(
    input logic                   single,
    input logic signed [IN_W-1:0] value
  );
    logic signed [IN_W:0] wide;
    wide = {value[IN_W-1], value};
    if (single) begin
      return wide - SINGLE_OFFSET;
    end
    return wide;
  endfunction

  // the extra bit keeps a saturating input from wrapping into range
  always_comb begin
    diff = aorf_to_diff(mode_single_i, sample_i);
  end

  // saturation and the flag are decided together, so they never disagree
  always_comb begin
    conv_w = aorf_convert(diff);
  end

  // half-cycle hold stage: coding settles on the falling edge and the
  // pipeline moves on the rising edge, so both halves of a period are used
  always_ff @(negedge clock_i) begin
    if (!resetn_i) begin
      hold_flag <= WORD_RESET.flag;
    end else begin
      hold_flag <= conv_w.flag;
    end
  end

  always_ff @(negedge clock_i) begin
    if (!resetn_i) begin
      hold_code <= WORD_RESET.code;
    end else begin
      hold_code <= conv_w.code;
    end
  end

  // the source holds a refused sample, so recapturing it on each falling
  // edge of a stall is harmless
  always_ff @(negedge clock_i) begin
    if (!resetn_i) begin
      hold_v <= 1'b0;
    end else begin
      hold_v <= sample_valid_i;
    end
  end

  // the whole pipeline stalls while the buffer is full, so no word is lost;
  // the cost is that bubbles are not squeezed out during a stall
  assign advance = pipe_s.ready;

  // flag stages: a flag only moves with its own code, so a high flag
  // lasts exactly until the next in-range word comes out
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < PIPE; i++) begin
        pipe_flag[i] <= WORD_RESET.flag;
      end
    end else if (advance) begin
      pipe_flag[0] <= hold_flag;
      for (int i = 1; i < PIPE; i++) begin
        pipe_flag[i] <= pipe_flag[i-1];
      end
    end
  end

  // code stages
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < PIPE; i++) begin
        pipe_code[i] <= WORD_RESET.code;
      end
    end else if (advance) begin
      pipe_code[0] <= hold_code;
      for (int i = 1; i < PIPE; i++) begin
        pipe_code[i] <= pipe_code[i-1];
      end
    end
  end

  // valid stages
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < PIPE; i++) begin
        pipe_v[i] <= 1'b0;
      end
    end else if (advance) begin
      pipe_v[0] <= hold_v;
      for (int i = 1; i < PIPE; i++) begin
        pipe_v[i] <= pipe_v[i-1];
      end
    end
  end

  assign pipe_s.valid = pipe_v[PIPE-1];
  assign pipe_s.data  = {pipe_flag[PIPE-1], pipe_code[PIPE-1]};

  // two-entry buffer between the pipeline and the receiver
  aorf_skid u_skid (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .up       (pipe_s),
    .down     (out_s)
  );

  assign out_s.ready = data_ready_i;
  assign out_w       = aorf_word_s'(out_s.data);

  // all outputs below are flops of the buffer
  assign sample_ready_o      = pipe_s.ready;
  assign data_valid_o        = out_s.valid;
  assign data_code_o         = out_w.code;
  assign out_of_range_flag_o = out_w.flag;

endmodule // aorf_top
